// File: hw/uib_regs.sv
// uib_regs: apb register slave for enables, fraction, count and status
// assumes apb master per protocol; zero wait states
`timescale 1ns/10ps
`default_nettype none
module uib_regs
   import uib_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [UIB_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [UIB_NFLAG-1:0] flags_in,
   output logic [31:0] prdata_out,
   output logic pslverr_out,
   output logic [15:0] irq_en_out,
   output logic [UIB_NFLAG-1:0] sticky_out,
   uib_baud_if.ctrl bus
);
   // ==========================================
   // registers
   logic [15:0] irq_en_r;
   logic [15:0] frac_r;
   logic [15:0] count_r;
   logic [UIB_NFLAG-1:0] sticky_r;
   logic [UIB_NFLAG-1:0] flags_d_r;
   logic wr;
   logic rd;
   logic mapped;
   assign wr = psel_in && penable_in && pwrite_in;
   assign rd = psel_in && penable_in && !pwrite_in;
   assign mapped = (paddr_in == UIB_ADDR_IRQ_EN) || (paddr_in == UIB_ADDR_FRAC) ||
      (paddr_in == UIB_ADDR_COUNT) || (paddr_in == UIB_ADDR_STATUS) ||
      (paddr_in == UIB_ADDR_FLAGS);
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         irq_en_r <= UIB_RESET_VAL;
         frac_r <= UIB_RESET_VAL;
         count_r <= UIB_RESET_VAL;
      end
      else if (wr)
      begin
         // reserved bits held at zero
         if (paddr_in == UIB_ADDR_IRQ_EN)
            irq_en_r <= pwdata_in[15:0] & UIB_IRQ_EN_MASK;
         if (paddr_in == UIB_ADDR_FRAC)
            frac_r <= pwdata_in[15:0] & UIB_FRAC_MASK;
         if (paddr_in == UIB_ADDR_COUNT)
            count_r <= pwdata_in[15:0];
      end
   end
   // ==========================================
   // sticky status on flag rise, set wins over clear
   logic [UIB_NFLAG-1:0] clr;
   assign clr = (wr && paddr_in == UIB_ADDR_STATUS) ? pwdata_in[UIB_NFLAG-1:0] : '0;
   genvar g;
   generate
      for (g = 0; g < UIB_NFLAG; g++)
      begin : g_st
         always_ff @(posedge clk_in or negedge nrst_in)
         begin
            if (!nrst_in)
               sticky_r[g] <= 1'b0;
            else if (flags_in[g] && !flags_d_r[g])
               sticky_r[g] <= 1'b1;
            else if (clr[g])
               sticky_r[g] <= 1'b0;
         end
      end
   endgenerate
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         flags_d_r <= '0;
      else
         flags_d_r <= flags_in;
   end
   // ==========================================
   // read data
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         prdata_out <= '0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pslverr_out <= psel_in && !penable_in && !mapped;
         prdata_out <= '0;
         if (psel_in && !penable_in && !pwrite_in)
            case (paddr_in)
               UIB_ADDR_IRQ_EN: prdata_out <= {16'h0000, irq_en_r};
               UIB_ADDR_FRAC: prdata_out <= {16'h0000, frac_r};
               UIB_ADDR_COUNT: prdata_out <= {16'h0000, count_r};
               UIB_ADDR_STATUS: prdata_out <= {28'h0000000, sticky_r};
               UIB_ADDR_FLAGS: prdata_out <= {28'h0000000, flags_in};
               default: prdata_out <= '0;
            endcase
      end
   end
   assign irq_en_out = irq_en_r;
   assign sticky_out = sticky_r;
   assign bus.integer_count = count_r;
   assign bus.fraction_sel = frac_r[UIB_FRAC_LSB +: UIB_FRAC_W];
   a_resv_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (irq_en_r & ~UIB_IRQ_EN_MASK) == '0 && (frac_r & ~UIB_FRAC_MASK) == '0)
      else $error("reserved bit set");
   a_frac_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
      wr && paddr_in == UIB_ADDR_FRAC |=> frac_r[7:4] == $past(pwdata_in[7:4]))
      else $error("fraction not stored");
   a_set_wins: assert property (@(posedge clk_in) disable iff (!nrst_in)
      flags_in[0] && !flags_d_r[0] |=> sticky_r[0]) else $error("event lost");
   a_rd_resv: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $past(rd) |-> prdata_out[31:16] == 16'h0000) else $error("upper bits nonzero");
endmodule // uib_regs
`default_nettype wire

// File: hw/uib_pkg.sv
// uib_pkg: register map, field positions and constants of the uart irq/baud block
// assumes a 32-bit apb slave, one aligned word per register
package uib_pkg;
   localparam logic [7:0] UIB_ADDR_IRQ_EN = 8'h00;
   localparam logic [7:0] UIB_ADDR_FRAC = 8'h04;
   localparam logic [7:0] UIB_ADDR_COUNT = 8'h08;
   localparam logic [7:0] UIB_ADDR_STATUS = 8'h0c;
   localparam logic [7:0] UIB_ADDR_FLAGS = 8'h10;
   localparam int UIB_ADDR_W = 8;
   localparam int UIB_BIT_RSE = 6;
   localparam int UIB_BIT_RX_FULL = 2;
   localparam int UIB_BIT_TSE = 1;
   localparam int UIB_BIT_TX_HOLD = 0;
   localparam logic [15:0] UIB_IRQ_EN_MASK = 16'h0047;
   localparam logic [15:0] UIB_FRAC_MASK = 16'h00f0;
   localparam int UIB_FRAC_LSB = 4;
   localparam int UIB_FRAC_W = 4;
   localparam int UIB_CNT_W = 16;
   localparam logic [15:0] UIB_RESET_VAL = 16'h0000;
   localparam int UIB_NFLAG = 4;
   typedef enum logic [1:0] {
      UIB_ST_IDLE = 2'b00,
      UIB_ST_LOAD = 2'b01,
      UIB_ST_RUN = 2'b10
   } uib_baud_state_e;
endpackage

// File: hw/uib_baud_if.sv
// uib_baud_if: divisor settings from the register file to the baud generator
// assumes both ends on clk_in
`timescale 1ns/10ps
`default_nettype none
interface uib_baud_if;
   import uib_pkg::*;
   logic [UIB_CNT_W-1:0] integer_count;
   logic [UIB_FRAC_W-1:0] fraction_sel;
   logic bit_tick;
   modport ctrl (output integer_count, output fraction_sel, input bit_tick);
   modport gen (input integer_count, input fraction_sel, output bit_tick);
endinterface
`default_nettype wire

// File: hw/uib_baud_gen.sv
// uib_baud_gen: fractional bit-period generator
// assumes settings stable while running; divisor zero halts ticks
`timescale 1ns/10ps
`default_nettype none
module uib_baud_gen
   import uib_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   uib_baud_if.gen bus
);
   // ==========================================
   // period counter with fraction accumulator
   uib_baud_state_e state_r;
   logic [UIB_CNT_W:0] cnt_r;
   logic [UIB_FRAC_W-1:0] acc_r;
   logic [UIB_FRAC_W:0] acc_sum;
   logic [UIB_CNT_W:0] reload;
   logic tick_r;
   assign acc_sum = {1'b0, acc_r} + {1'b0, bus.fraction_sel};
   // period = integer plus one when fraction overflows
   assign reload = {1'b0, bus.integer_count} + {{UIB_CNT_W{1'b0}}, acc_sum[UIB_FRAC_W]};
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_r <= UIB_ST_IDLE;
         cnt_r <= '0;
         acc_r <= '0;
         tick_r <= 1'b0;
      end
      else
      begin
         tick_r <= 1'b0;
         case (state_r)
            UIB_ST_IDLE:
               if (bus.integer_count != '0)
                  state_r <= UIB_ST_LOAD;
            UIB_ST_LOAD:
            begin
               cnt_r <= reload;
               acc_r <= acc_sum[UIB_FRAC_W-1:0];
               state_r <= UIB_ST_RUN;
            end
            UIB_ST_RUN:
            begin
               if (bus.integer_count == '0)
               begin
                  // count cleared: stop at once
                  state_r <= UIB_ST_IDLE;
                  cnt_r <= '0;
               end
               else if (cnt_r <= {{UIB_CNT_W{1'b0}}, 1'b1})
               begin
                  // reload on the tick, no idle cycle between periods
                  tick_r <= 1'b1;
                  cnt_r <= reload;
                  acc_r <= acc_sum[UIB_FRAC_W-1:0];
               end
               else
                  cnt_r <= cnt_r - {{UIB_CNT_W{1'b0}}, 1'b1};
            end
            default: state_r <= UIB_ST_IDLE;
         endcase
      end
   end
   assign bus.bit_tick = tick_r;
   a_tick_single: assert property (@(posedge clk_in) disable iff (!nrst_in)
      tick_r && cnt_r != {{UIB_CNT_W{1'b0}}, 1'b1} |=> !tick_r)
      else $error("bit tick lasted two cycles");
endmodule // uib_baud_gen
`default_nettype wire

// File: hw/uib_top.sv
// uib_top: uart interrupt enables and fractional baud correction, apb slave
// assumes status flags from the uart core on clk_in
// ==========================================
// Summary of operation
// - enable register unused bits read zero
// - bit 6 gates receive sum error
// - bit 2 gates receive buffer full
// - bit 1 gates transmit shift empty
// - bit 0 gates transmit holding empty
// - fraction register unused bits read zero
// - bits 7..4 give sixteenths of fraction
// - divisor equals integer count plus fraction
// - integer count is 16 bits, resets zero
`timescale 1ns/10ps
`default_nettype none
module uib_top
   import uib_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [UIB_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic rx_sum_error_flag_in,
   input wire logic rx_full_flag_in,
   input wire logic tx_shift_empty_flag_in,
   input wire logic tx_holding_empty_flag_in,
   output logic bit_tick_out,
   output logic uart_irq_out
);
   // ==========================================
   // flag gathering
   logic [UIB_NFLAG-1:0] flags;
   logic [15:0] irq_en;
   logic [UIB_NFLAG-1:0] sticky;
   logic [UIB_NFLAG-1:0] en4;
   logic irq_nxt;
   logic irq_r;
   logic tick_r;
   logic pready_r;
   uib_baud_if bif();
   assign flags = {rx_sum_error_flag_in, rx_full_flag_in, tx_shift_empty_flag_in,
      tx_holding_empty_flag_in};
   uib_regs u_regs (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .pwdata_in(pwdata_in),
      .flags_in(flags),
      .prdata_out(prdata_out),
      .pslverr_out(pslverr_out),
      .irq_en_out(irq_en),
      .sticky_out(sticky),
      .bus(bif.ctrl)
   );
   uib_baud_gen u_baud (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .bus(bif.gen)
   );
   // ==========================================
   // interrupt gating
   // sum error, rx full, tx shift, tx holding order in flag vector
   assign en4 = {irq_en[UIB_BIT_RSE],
      irq_en[UIB_BIT_RX_FULL],
      irq_en[UIB_BIT_TSE],
      irq_en[UIB_BIT_TX_HOLD]};
   assign irq_nxt = |(sticky & en4);
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         irq_r <= 1'b0;
      else
         irq_r <= irq_nxt;
   end
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         tick_r <= 1'b0;
      else
         tick_r <= bif.bit_tick;
   end
   // zero wait states, ready from a flop
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         pready_r <= 1'b0;
      else
         pready_r <= 1'b1;
   end
   assign uart_irq_out = irq_r;
   assign bit_tick_out = tick_r;
   assign pready_out = pready_r;
   a_irq_gate: assert property (@(posedge clk_in) disable iff (!nrst_in)
      irq_nxt |=> uart_irq_out) else $error("irq not raised");
   a_rse_mask: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !irq_en[UIB_BIT_RSE] && sticky == 4'h8 |=> !uart_irq_out)
      else $error("masked sum error interrupts");
   a_rx_full_mask: assert property (@(posedge clk_in) disable iff (!nrst_in)
      irq_en[UIB_BIT_RX_FULL] && sticky[2] |=> uart_irq_out)
      else $error("full flag irq missing");
   a_tse_mask: assert property (@(posedge clk_in) disable iff (!nrst_in)
      irq_en[UIB_BIT_TSE] && sticky[1] |=> uart_irq_out)
      else $error("shift empty irq missing");
   a_tx_hold_mask: assert property (@(posedge clk_in) disable iff (!nrst_in)
      irq_en[UIB_BIT_TX_HOLD] && sticky[0] |=> uart_irq_out)
      else $error("holding empty irq missing");
   a_none_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
      irq_en == '0 |=> !uart_irq_out) else $error("irq with all masked");
endmodule // uib_top
`default_nettype wire

// File: tb/uib_uart_model.sv
// uib_uart_model: far-side uart core that raises the four status flags
// assumes event commands from the bench on clk_in
`timescale 1ns/10ps
`default_nettype none
module uib_uart_model (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [3:0] ev_in,
   output logic [3:0] flags_out
);
   // flags follow commanded events one cycle later
   // no transmit byte is loaded here, so none lands while holding empty is low
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         flags_out <= 4'h0;
      else
         flags_out <= ev_in;
   end
endmodule // uib_uart_model
`default_nettype wire

// File: tb/uart_irq_mask_baud_fraction_tb_top.sv
// uart_irq_mask_baud_fraction_tb_top: self-checking bench of the irq/baud block
// assumes zero-wait apb slave and the uart core model
`timescale 1ns/10ps
`default_nettype none
module uart_irq_mask_baud_fraction_tb_top;
   import uib_pkg::*;
   logic clk_in, nrst_in, psel, penable, pwrite, pready, pslverr, tick, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] ev, flags;
   logic [15:0] lf;
   int errors, checked, n, m_cnt, m_frac;
   int eb[4] = '{0, 1, 2, 6};
   uib_top uib_top_inst (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .rx_sum_error_flag_in(flags[3]), .rx_full_flag_in(flags[2]),
      .tx_shift_empty_flag_in(flags[1]), .tx_holding_empty_flag_in(flags[0]),
      .bit_tick_out(tick), .uart_irq_out(irq));
   uib_uart_model uib_uart_model_inst (.clk_in(clk_in), .nrst_in(nrst_in), .ev_in(ev),
      .flags_out(flags));
   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   // ==========================================
   // helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task results();
      if (errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int c);
      repeat (c) @(posedge clk_in);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk_in);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      rd = prdata;
      if (k == 50)
      begin
         errors++;
         $display("ERROR %0t apb timeout", $time);
         results();
      end
      chk({31'h0, pslverr}, {31'h0, e});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_in);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0);
      chk(rd, exp);
   endtask
   task ticks(input int c, input int f);
      int k, t;
      k = 0;
      t = 0;
      for (n = 0; n < 3000 && t < 18; n++)
      begin
         @(posedge clk_in);
         if (t >= 2)
            k++;
         if (tick === 1'b1)
            t++;
      end
      if (t < 18)
      begin
         errors++;
         $display("ERROR %0t bit tick timeout", $time);
         results();
      end
      chk(k, 16 * c + f);
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      nrst_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ev = 4'h0;
      errors = 0;
      checked = 0;
      lf = 16'h6f42;
      cyc(2);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      for (int i = 0; i < 5; i++)
         rdc(8'(4 * i), 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         lf = lfsr(lf);
         wr(UIB_ADDR_IRQ_EN, {lf, lf & 16'hfffd});
         rdc(UIB_ADDR_IRQ_EN, {16'h0, lf & 16'h0045});
         wr(UIB_ADDR_FRAC, {lf, lf});
         rdc(UIB_ADDR_FRAC, {16'h0, lf & 16'h00f0});
         wr(UIB_ADDR_COUNT, {lf, lf});
         rdc(UIB_ADDR_COUNT, {16'h0, lf});
      end
      apb(1'b1, 8'h14, 32'hffffffff, 1'b1);
      apb(1'b0, 8'h14, 32'h0, 1'b1);
      chk(rd, 32'h0);
      wr(UIB_ADDR_IRQ_EN, 32'h0);
      wr(UIB_ADDR_STATUS, 32'hf);
      for (int i = 0; i < 4; i++)
      begin
         ev <= 4'(1 << i);
         cyc(4);
         chk({31'h0, irq}, 32'h0);
         rdc(UIB_ADDR_FLAGS, 32'(1 << i));
         rdc(UIB_ADDR_STATUS, 32'(1 << i));
         wr(UIB_ADDR_IRQ_EN, 32'(1 << eb[i]));
         cyc(2);
         chk({31'h0, irq}, 32'h1);
         ev <= 4'h0;
         wr(UIB_ADDR_STATUS, 32'(1 << i));
         cyc(2);
         chk({31'h0, irq}, 32'h0);
         rdc(UIB_ADDR_STATUS, 32'h0);
      end
      for (int j = 0; j < 4; j++)
      begin
         lf = lfsr(lf);
         m_frac = (j == 3) ? 15 : j * 5;
         m_cnt = 2 + lf % 5;
         wr(UIB_ADDR_COUNT, 32'h0);
         wr(UIB_ADDR_FRAC, 32'(m_frac << 4));
         wr(UIB_ADDR_COUNT, 32'(m_cnt));
         ticks(m_cnt, m_frac);
      end
      wr(UIB_ADDR_COUNT, 32'h0);
      cyc(4);
      n = 0;
      repeat (60)
      begin
         @(posedge clk_in);
         if (tick === 1'b1)
            n++;
      end
      chk(n, 0);
      results();
   end
endmodule // uart_irq_mask_baud_fraction_tb_top
`default_nettype wire
